// File: rtl/siw_ctrl.sv
// interrupt priority controller, watchdog control, protection control and reset cause
// assumes: external request pins are asynchronous and active low; the other sources, the
// halt flag and the acknowledge request come from logic on this clock
//
// Strobed register access is this design's own decision.
module siw_ctrl #(
  parameter int unsigned WD_BASE_LOG2  = siw_pkg::WD_BASE_LOG2,
  parameter int unsigned WD_PRESC_LOG2 = siw_pkg::WD_PRESC_LOG2
) (
  input  wire logic                   clock,               // system clock, 100 MHz
  input  wire logic                   nrst,                // system reset, async, active low
  input  wire siw_pkg::siw_bus_s      bus,                 // register port request
  output logic [siw_pkg::DATA_W-1:0]  rdata_q,             // read data, cycle after read strobe
  input  wire logic [3:0]             irq_pin_n,           // external request lines, active low
  input  wire logic                   timer_one_irq,       // timer channel one request
  input  wire logic                   timer_two_irq,       // timer channel two request
  input  wire logic                   serial_irq,          // serial port request
  input  wire logic                   cpu_halted,          // core halted
  input  wire siw_pkg::siw_iack_req_s iack_req,            // acknowledge request with level
  output siw_pkg::siw_iack_rsp_s      iack_rsp_q,          // acknowledge answer
  output logic [2:0]                  core_level_q,        // request level to the core
  output logic                        watchdog_reset_q,    // hardware reset pulse
  output logic                        bus_monitor_run_q,   // bus monitor may count
  output logic [10:0]                 bus_monitor_limit_q  // bus monitor timeout in clocks
);
  import siw_pkg::*;

  logic [3:0]         ext_s1_q;
  logic [3:0]         ext_s2_q;
  logic [3:0]         ext_s3_q;
  logic [3:0]         ext_q;
  logic [NUM_SRC-1:0] src_req;
  logic [NUM_SRC-1:0] pend_q;
  logic [31:0]        mask_q;
  siw_lvl_s           lvl_q [NUM_SRC];
  siw_lvl_s           eff   [NUM_SRC];
  siw_prot_s          prot_q;
  logic               prot_done_q;
  logic [7:0]         cause_q;
  logic [7:0]         wd_vec_q;
  logic [7:0]         sys_cfg_q;
  siw_svc_e           svc_q;
  logic               svc_hit;
  logic               wd_irq_q;
  logic               wd_timeout;
  logic               sreset_q;
  logic [NUM_SRC-1:0] active;
  logic [4:0]         best_key;
  logic               ack_hit;
  logic [2:0]         ack_idx;
  logic [1:0]         ack_prio;
  logic [31:0]        pend_word;
  logic [31:0]        rd_mux;
  logic               wr_svc;

  assign wr_svc  = bus.wr && (bus.addr == ADDR_WD_SVC);
  assign src_req = {serial_irq, timer_two_irq, timer_one_irq, wd_irq_q, ext_q};

  // three stages; a level is taken only once the last two agree, which rejects single glitches
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ext_s1_q <= 4'h0;
      ext_s2_q <= 4'h0;
      ext_s3_q <= 4'h0;
      ext_q    <= 4'h0;
    end else begin
      ext_s1_q <= ~irq_pin_n;
      ext_s2_q <= ext_s1_q;
      ext_s3_q <= ext_s2_q;
      ext_q    <= (ext_s2_q & ext_s3_q) | (ext_q & (ext_s2_q ^ ext_s3_q));
    end
  end

  // pending mirrors the live request; the source itself withdraws it after acknowledge
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      pend_q <= '0;
    end else if (sreset_q) begin
      pend_q <= '0;
    end else begin
      pend_q <= src_req;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      mask_q <= MASK_RESET;
    end else if (sreset_q) begin
      mask_q <= MASK_RESET;
    end else if (bus.wr && (bus.addr == ADDR_MASK)) begin
      mask_q <= bus.wdata & MASK_USED;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < NUM_SRC; i++) begin
        lvl_q[i] <= LVL_RESET[i];
      end
    end else if (sreset_q) begin
      for (int i = 0; i < NUM_SRC; i++) begin
        lvl_q[i] <= LVL_RESET[i];
      end
    end else if (bus.wr) begin
      for (int i = 0; i < NUM_SRC; i++) begin
        if (bus.addr == LVL_ADDR[i]) begin
          lvl_q[i] <= bus.wdata[7:0];
        end
      end
    end
  end

  // hardwired fields override the stored bits both in arbitration and on readback
  always_comb begin
    for (int i = 0; i < NUM_SRC; i++) begin
      eff[i] = lvl_q[i];
      eff[i].unused = 2'h0;
    end
    if (prot_q.watchdog_enable && !prot_q.watchdog_reset_or_interrupt) begin
      eff[SRC_WDOG].request_level_field = LEVEL_TOP;
    end
    eff[SRC_TMR1].auto_vector_select = 1'b1;
    eff[SRC_TMR2].auto_vector_select = 1'b1;
  end

  // equal keys fall to the lower source index, so duplicates stay deterministic here
  always_comb begin
    best_key = 5'h00;
    ack_hit  = 1'b0;
    ack_idx  = 3'h0;
    ack_prio = 2'h0;
    for (int i = 0; i < NUM_SRC; i++) begin
      active[i] = pend_q[i] && !mask_q[SRC_BIT[i]] &&
                  (eff[i].request_level_field != LEVEL_NONE);
      if (active[i] && ({eff[i].request_level_field, eff[i].sub_priority_field} > best_key)) begin
        best_key = {eff[i].request_level_field, eff[i].sub_priority_field};
      end
      if (active[i] && (eff[i].request_level_field == iack_req.level) &&
          (!ack_hit || (eff[i].sub_priority_field > ack_prio))) begin
        ack_hit  = 1'b1;
        ack_idx  = 3'(i);
        ack_prio = eff[i].sub_priority_field;
      end
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      core_level_q <= LEVEL_NONE;
    end else if (sreset_q) begin
      core_level_q <= LEVEL_NONE;
    end else begin
      core_level_q <= best_key[4:2];
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      iack_rsp_q <= '0;
    end else begin
      iack_rsp_q <= '0;
      if (iack_req.valid && !sreset_q) begin
        iack_rsp_q.valid <= 1'b1;
        if (!ack_hit) begin
          iack_rsp_q.device_vector <= 1'b1;
          iack_rsp_q.vector        <= SPURIOUS_VEC;
        end else if (ack_idx == 3'(SRC_WDOG)) begin
          iack_rsp_q.source        <= NUM_SRC'(1) << ack_idx;
          iack_rsp_q.device_vector <= 1'b1;
          iack_rsp_q.vector        <= wd_vec_q;
        end else if (eff[ack_idx].auto_vector_select) begin
          iack_rsp_q.source        <= NUM_SRC'(1) << ack_idx;
          iack_rsp_q.device_vector <= 1'b1;
          iack_rsp_q.vector        <= AUTOVEC_BASE + {5'h00, iack_req.level};
        end else begin
          iack_rsp_q.source        <= NUM_SRC'(1) << ack_idx;
        end
      end
    end
  end

  // watchdog request is held until its own acknowledge; a new timeout in that cycle wins
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      wd_irq_q <= 1'b0;
    end else if (sreset_q) begin
      wd_irq_q <= 1'b0;
    end else if (wd_timeout && !prot_q.watchdog_reset_or_interrupt) begin
      wd_irq_q <= 1'b1;
    end else if (iack_req.valid && ack_hit && (ack_idx == 3'(SRC_WDOG))) begin
      wd_irq_q <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      sreset_q         <= 1'b0;
      watchdog_reset_q <= 1'b0;
    end else begin
      sreset_q         <= wd_timeout && prot_q.watchdog_reset_or_interrupt;
      watchdog_reset_q <= wd_timeout && prot_q.watchdog_reset_or_interrupt;
    end
  end

  // the cause is recorded in the cycle the internal reset ends
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      cause_q <= CAUSE_HARD;
    end else if (sreset_q) begin
      cause_q <= CAUSE_WDOG;
    end else if (bus.wr && (bus.addr == ADDR_CAUSE)) begin
      cause_q <= cause_q & ~(bus.wdata[7:0] & CAUSE_USED);
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      prot_q      <= PROT_RESET;
      prot_done_q <= 1'b0;
    end else if (sreset_q) begin
      prot_q      <= PROT_RESET;
      prot_done_q <= 1'b0;
    end else if (bus.wr && (bus.addr == ADDR_PROT) && !prot_done_q) begin
      prot_q      <= bus.wdata[7:0];
      prot_done_q <= 1'b1;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      wd_vec_q <= WD_VEC_RESET;
    end else if (sreset_q) begin
      wd_vec_q <= WD_VEC_RESET;
    end else if (bus.wr && (bus.addr == ADDR_WD_VEC)) begin
      wd_vec_q <= bus.wdata[7:0];
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      sys_cfg_q <= SYS_CFG_RESET;
    end else if (sreset_q) begin
      sys_cfg_q <= SYS_CFG_RESET;
    end else if (bus.wr && (bus.addr == ADDR_SYS_CFG)) begin
      sys_cfg_q <= bus.wdata[7:0] & SYS_CFG_USED;
    end
  end

  // any service write other than the expected byte or a repeated first byte drops the sequence back to the start
  assign svc_hit = wr_svc && (svc_q == SVC_ARMED) && (bus.wdata[7:0] == SVC_SECOND);

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      svc_q <= SVC_IDLE;
    end else if (sreset_q) begin
      svc_q <= SVC_IDLE;
    end else if (wr_svc) begin
      unique case (svc_q)
        SVC_IDLE: begin
          svc_q <= (bus.wdata[7:0] == SVC_FIRST) ? SVC_ARMED : SVC_IDLE;
        end
        SVC_ARMED: begin
          svc_q <= (bus.wdata[7:0] == SVC_FIRST) ? SVC_ARMED : SVC_IDLE;
        end
        default: begin
          svc_q <= SVC_IDLE;
        end
      endcase
    end
  end

  siw_wdog_timer #(
    .BASE_LOG2  (WD_BASE_LOG2),
    .PRESC_LOG2 (WD_PRESC_LOG2)
  ) u_wdog (
    .clock       (clock),
    .nrst        (nrst),
    .clear       (sreset_q),
    .enable      (prot_q.watchdog_enable),
    .freeze      (sys_cfg_q[FRZ_WDOG_BIT] && cpu_halted),
    .prescale    (prot_q.watchdog_prescale),
    .timing_code (prot_q.watchdog_timing_code),
    .service     (svc_hit),
    .timeout_q   (wd_timeout)
  );

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      bus_monitor_run_q   <= 1'b0;
      bus_monitor_limit_q <= BM_LIMIT_MAX;
    end else begin
      bus_monitor_run_q   <= prot_q.bus_monitor_enable &&
                             !(sys_cfg_q[FRZ_BMON_BIT] && cpu_halted);
      bus_monitor_limit_q <= BM_LIMIT_MAX >> prot_q.bus_monitor_timing_code;
    end
  end

  always_comb begin
    pend_word = 32'h0;
    for (int i = 0; i < NUM_SRC; i++) begin
      pend_word[SRC_BIT[i]] = pend_q[i];
    end
    rd_mux = 32'h0;
    for (int i = 0; i < NUM_SRC; i++) begin
      if (bus.addr == LVL_ADDR[i]) begin
        rd_mux = {24'h0, eff[i]};
      end
    end
    case (bus.addr)
      ADDR_SYS_CFG: rd_mux = {24'h0, sys_cfg_q};
      ADDR_MASK:    rd_mux = mask_q;
      ADDR_PEND:    rd_mux = pend_word;
      ADDR_CAUSE:   rd_mux = {24'h0, cause_q};
      ADDR_PROT:    rd_mux = {24'h0, prot_q};
      default:      rd_mux = rd_mux;
    endcase
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rdata_q <= 32'h0;
    end else begin
      rdata_q <= bus.rd ? rd_mux : 32'h0;
    end
  end

endmodule : siw_ctrl

// File: rtl/siw_pkg.sv
// constants, register map and carrier types of the interrupt, watchdog and protection control block
// assumes one 100 MHz clock and a register port with read data one cycle after the strobe
package siw_pkg;

  localparam int unsigned ADDR_W  = 8;
  localparam int unsigned DATA_W  = 32;
  localparam int unsigned NUM_SRC = 8;

  // source order: external 0..3, watchdog, timer one, timer two, serial port
  localparam int unsigned SRC_WDOG = 4;
  localparam int unsigned SRC_TMR1 = 5;
  localparam int unsigned SRC_TMR2 = 6;

  localparam logic [ADDR_W-1:0] ADDR_SYS_CFG  = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_MASK     = 8'h34;
  localparam logic [ADDR_W-1:0] ADDR_PEND     = 8'h38;
  localparam logic [ADDR_W-1:0] ADDR_CAUSE    = 8'h40;
  localparam logic [ADDR_W-1:0] ADDR_PROT     = 8'h41;
  localparam logic [ADDR_W-1:0] ADDR_WD_VEC   = 8'h42;
  localparam logic [ADDR_W-1:0] ADDR_WD_SVC   = 8'h43;

  localparam logic [NUM_SRC-1:0][ADDR_W-1:0] LVL_ADDR =
    {8'h1f, 8'h1d, 8'h1c, 8'h1b, 8'h17, 8'h16, 8'h15, 8'h14};
  localparam logic [NUM_SRC-1:0][7:0] LVL_RESET =
    {8'h18, 8'h94, 8'h90, 8'h1f, 8'h0c, 8'h08, 8'h04, 8'h1c};
  localparam logic [NUM_SRC-1:0][4:0] SRC_BIT =
    {5'h0c, 5'h0a, 5'h09, 5'h08, 5'h04, 5'h03, 5'h02, 5'h01};

  localparam logic [31:0] MASK_RESET    = 32'h0000171e;
  localparam logic [31:0] MASK_USED     = 32'h0000171e;
  localparam logic [7:0]  CAUSE_HARD    = 8'h80;
  localparam logic [7:0]  CAUSE_WDOG    = 8'h20;
  localparam logic [7:0]  CAUSE_USED    = 8'ha0;
  localparam logic [7:0]  PROT_RESET    = 8'h00;
  localparam logic [7:0]  WD_VEC_RESET  = 8'h0f;
  localparam logic [7:0]  SYS_CFG_RESET = 8'h60;
  localparam logic [7:0]  SYS_CFG_USED  = 8'h60;
  localparam int unsigned FRZ_WDOG_BIT  = 6;
  localparam int unsigned FRZ_BMON_BIT  = 5;

  localparam logic [7:0]  SVC_FIRST     = 8'h55;
  localparam logic [7:0]  SVC_SECOND    = 8'haa;
  localparam logic [7:0]  AUTOVEC_BASE  = 8'h18;
  localparam logic [7:0]  SPURIOUS_VEC  = 8'h18;
  localparam logic [2:0]  LEVEL_TOP     = 3'h7;
  localparam logic [2:0]  LEVEL_NONE    = 3'h0;

  // watchdog period is 2^(base + 2*code) clocks, times 2^presc when prescaled
  localparam int unsigned WD_BASE_LOG2  = 9;
  localparam int unsigned WD_PRESC_LOG2 = 9;
  localparam logic [10:0] BM_LIMIT_MAX  = 11'h400;

  typedef struct packed {
    logic       auto_vector_select;
    logic [1:0] unused;
    logic [2:0] request_level_field;
    logic [1:0] sub_priority_field;
  } siw_lvl_s;

  typedef struct packed {
    logic       watchdog_enable;
    logic       watchdog_reset_or_interrupt;
    logic       watchdog_prescale;
    logic [1:0] watchdog_timing_code;
    logic       bus_monitor_enable;
    logic [1:0] bus_monitor_timing_code;
  } siw_prot_s;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } siw_bus_s;

  typedef struct packed {
    logic       valid;
    logic [2:0] level;
  } siw_iack_req_s;

  typedef struct packed {
    logic               valid;
    logic               device_vector;
    logic [NUM_SRC-1:0] source;
    logic [7:0]         vector;
  } siw_iack_rsp_s;

  typedef enum logic [1:0] {
    SVC_IDLE  = 2'b01,
    SVC_ARMED = 2'b10
  } siw_svc_e;

endpackage : siw_pkg

// File: rtl/siw_wdog_timer.sv
// watchdog period counter with optional prescaler
// assumes config and service come from logic on the same clock
module siw_wdog_timer #(
  parameter int unsigned BASE_LOG2  = 9,
  parameter int unsigned PRESC_LOG2 = 9
) (
  input  wire logic       clock,       // system clock
  input  wire logic       nrst,        // async reset, active low
  input  wire logic       clear,       // synchronous restart after a watchdog reset
  input  wire logic       enable,      // watchdog enabled
  input  wire logic       freeze,      // core halted and freezing selected
  input  wire logic       prescale,    // requested prescale
  input  wire logic [1:0] timing_code, // requested timing code
  input  wire logic       service,     // completed service sequence
  output logic            timeout_q    // one-cycle timeout pulse
);
  localparam int unsigned CNT_W = BASE_LOG2 + 6;

  logic                  act_presc_q;
  logic [1:0]            act_code_q;
  logic [PRESC_LOG2-1:0] presc_q;
  logic [CNT_W-1:0]      cnt_q;
  logic [CNT_W-1:0]      last_cnt;
  logic                  tick;
  logic                  at_last;

  assign last_cnt = {CNT_W{1'b1}} >> (3'h6 - {act_code_q, 1'b0});
  assign tick     = !act_presc_q || (presc_q == {PRESC_LOG2{1'b1}});
  assign at_last  = tick && (cnt_q == last_cnt);

  // a changed selection is only adopted at a service, so a stray write cannot shorten a running period
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      act_presc_q <= 1'b0;
      act_code_q  <= 2'h0;
    end else if (clear) begin
      act_presc_q <= 1'b0;
      act_code_q  <= 2'h0;
    end else if (service) begin
      act_presc_q <= prescale;
      act_code_q  <= timing_code;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      presc_q <= '0;
      cnt_q   <= '0;
    end else if (clear || !enable || service) begin
      presc_q <= '0;
      cnt_q   <= '0;
    end else if (!freeze) begin
      presc_q <= presc_q + 1'b1;
      if (tick) begin
        cnt_q <= at_last ? '0 : cnt_q + 1'b1;
      end
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      timeout_q <= 1'b0;
    end else begin
      timeout_q <= enable && !freeze && !clear && !service && at_last;
    end
  end

endmodule : siw_wdog_timer

// File: test/siw_periph_model.sv
// timer one, timer two and serial port request sources facing the control block
// assumes raise pulses come from the bench on the same clock
module siw_periph_model (
  input  wire logic                   clock,    // system clock
  input  wire logic                   nrst,     // reset, active low
  input  wire logic [2:0]             raise,    // request pulse: timer one, timer two, serial
  input  wire logic                   slow,     // drop late after the acknowledge
  input  wire siw_pkg::siw_iack_rsp_s iack_rsp, // acknowledge answer of the block
  output logic [2:0]                  req_q     // request levels
);
  import siw_pkg::*;
  logic [2:0] done_q;
  logic [1:0] wait_q;
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      req_q  <= '0;
      done_q <= '0;
      wait_q <= '0;
    end else begin
      wait_q <= (done_q != '0) ? wait_q + 2'd1 : 2'd0;
      for (int i = 0; i < 3; i++) begin
        if (iack_rsp.valid && iack_rsp.source[SRC_TMR1+i]) done_q[i] <= 1'b1;
        if (raise[i]) req_q[i] <= 1'b1;
        // a slow source keeps its request a few cycles past the acknowledge
        if (done_q[i] && (!slow || wait_q == 2'd3)) begin
          req_q[i]  <= 1'b0;
          done_q[i] <= 1'b0;
        end
      end
    end
  end
endmodule : siw_periph_model

// File: test/siw_ctrl_monitor.sv
// concurrent checks on the ports of the control block
// assumes one clock and the asynchronous active-low reset
module siw_ctrl_monitor #(
  parameter int unsigned WD_BASE_LOG2  = 9,
  parameter int unsigned WD_PRESC_LOG2 = 9
) (
  input wire logic                   clock,               // system clock
  input wire logic                   nrst,                // reset, active low
  input wire siw_pkg::siw_bus_s      bus,                 // register port
  input wire logic [31:0]            rdata_q,             // read data
  input wire logic [3:0]             irq_pin_n,           // external lines
  input wire logic                   timer_one_irq,       // timer one request
  input wire logic                   timer_two_irq,       // timer two request
  input wire logic                   serial_irq,          // serial request
  input wire logic                   cpu_halted,          // core halted
  input wire siw_pkg::siw_iack_req_s iack_req,            // acknowledge request
  input wire siw_pkg::siw_iack_rsp_s iack_rsp_q,          // acknowledge answer
  input wire logic [2:0]             core_level_q,        // level to the core
  input wire logic                   watchdog_reset_q,    // reset pulse
  input wire logic                   bus_monitor_run_q,   // monitor may count
  input wire logic [10:0]            bus_monitor_limit_q  // monitor timeout
);
  import siw_pkg::*;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  rd_idle_a: assert property (!bus.rd |=> rdata_q == '0) else $error("read data outside read slot");
  iack_answer_a: assert property (iack_req.valid && !watchdog_reset_q |=> iack_rsp_q.valid)
    else $error("acknowledge not answered");
  iack_cause_a: assert property (iack_rsp_q.valid |-> $past(iack_req.valid)) else $error("answer without request");
  auto_vector_a: assert property (iack_rsp_q.valid && iack_rsp_q.device_vector && iack_rsp_q.source != '0
    && !iack_rsp_q.source[SRC_WDOG] |-> iack_rsp_q.vector == AUTOVEC_BASE + {5'h0, $past(iack_req.level)})
    else $error("autovector number wrong");
  one_winner_a: assert property (iack_rsp_q.valid |-> $onehot0(iack_rsp_q.source)) else $error("several winners");
  timer_auto_vector_select_a: assert property (iack_rsp_q.valid && !iack_rsp_q.device_vector |-> iack_rsp_q.source != '0
    && !iack_rsp_q.source[SRC_TMR1] && !iack_rsp_q.source[SRC_TMR2]) else $error("timer not autovectored");
  wdog_vector_a: assert property (iack_rsp_q.valid && iack_rsp_q.source[SRC_WDOG] |-> iack_rsp_q.device_vector)
    else $error("watchdog vector not supplied");
  no_winner_a: assert property (iack_rsp_q.valid && iack_rsp_q.source == '0
    |-> iack_rsp_q.device_vector && iack_rsp_q.vector == SPURIOUS_VEC) else $error("empty acknowledge wrong");
  soft_reset_a: assert property (watchdog_reset_q |-> ##2 (!bus_monitor_run_q && bus_monitor_limit_q == BM_LIMIT_MAX))
    else $error("monitor not reset by watchdog");
  limit_set_a: assert property (bus_monitor_limit_q inside {11'h400, 11'h200, 11'h100, 11'h080})
    else $error("monitor limit illegal");
  cover property (watchdog_reset_q);
  cover property (iack_rsp_q.valid && !iack_rsp_q.device_vector);
  cover property (iack_rsp_q.valid && iack_rsp_q.source[SRC_WDOG]);
endmodule : siw_ctrl_monitor

bind siw_ctrl siw_ctrl_monitor #(.WD_BASE_LOG2(WD_BASE_LOG2), .WD_PRESC_LOG2(WD_PRESC_LOG2)) siw_ctrl_monitor_i (
  .clock(clock), .nrst(nrst), .bus(bus), .rdata_q(rdata_q), .irq_pin_n(irq_pin_n), .timer_one_irq(timer_one_irq),
  .timer_two_irq(timer_two_irq), .serial_irq(serial_irq), .cpu_halted(cpu_halted), .iack_req(iack_req),
  .iack_rsp_q(iack_rsp_q), .core_level_q(core_level_q), .watchdog_reset_q(watchdog_reset_q),
  .bus_monitor_run_q(bus_monitor_run_q), .bus_monitor_limit_q(bus_monitor_limit_q));

// File: test/tb_top.sv
// self-checking bench of the interrupt, watchdog and protection control block
// assumes the periph model drives timer and serial requests; the bench acts as core and software
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import siw_pkg::*;
  logic clock = 1'b0, nrst = 1'b0, cpu_halted = 1'b0, slow = 1'b0, wd_rst, bm_run;
  siw_bus_s bus = '0;
  siw_iack_req_s iack_req = '0;
  siw_iack_rsp_s iack_rsp;
  logic [3:0] irq_pin_n = 4'hf;
  logic [2:0] raise = '0, per_irq, core_level;
  logic [10:0] bm_limit;
  logic [31:0] rdata_q, v;
  logic [7:0] d;
  int err_count = 0, total_checks = 0, wd_hits = 0, seed = 32'h32e35138;
  always #5 clock = ~clock;
  always @(posedge clock) if (wd_rst === 1'b1) wd_hits++;
  siw_ctrl #(.WD_BASE_LOG2(2), .WD_PRESC_LOG2(2)) siw_ctrl_i (.clock(clock), .nrst(nrst), .bus(bus),
    .rdata_q(rdata_q), .irq_pin_n(irq_pin_n), .timer_one_irq(per_irq[0]), .timer_two_irq(per_irq[1]),
    .serial_irq(per_irq[2]), .cpu_halted(cpu_halted), .iack_req(iack_req), .iack_rsp_q(iack_rsp),
    .core_level_q(core_level), .watchdog_reset_q(wd_rst), .bus_monitor_run_q(bm_run), .bus_monitor_limit_q(bm_limit));
  siw_periph_model siw_periph_model_i (.clock(clock), .nrst(nrst), .raise(raise), .slow(slow), .iack_rsp(iack_rsp),
    .req_q(per_irq));
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : report_and_stop
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask : cyc
  // every request drops at the taking edge and the task leaves 1 ns later, so no signal is set twice at once
  task automatic wr(input logic [7:0] a, input logic [31:0] x);
    bus <= '{addr: a, wdata: x, wr: 1'b1, rd: 1'b0};
    @(posedge clock);
    bus <= '0;
    #1;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    bus <= '{addr: a, wdata: '0, wr: 1'b0, rd: 1'b1};
    @(posedge clock);
    bus <= '0;
    #1 chk($sformatf("register %h", a), exp, rdata_q);
  endtask : rd
  task automatic ack(input logic [2:0] lvl, input logic [17:0] exp);
    iack_req <= '{valid: 1'b1, level: lvl};
    @(posedge clock);
    iack_req <= '0;
    #1 chk("acknowledge", exp, {iack_rsp.valid, iack_rsp.device_vector, iack_rsp.source,
      iack_rsp.device_vector ? iack_rsp.vector : 8'h00});
  endtask : ack
  task automatic pulse(input logic [2:0] r);
    raise <= r;
    @(posedge clock);
    raise <= '0;
    #1;
  endtask : pulse
  task automatic do_reset();
    nrst <= 1'b0;
    cyc(12);
    nrst <= 1'b1;
  endtask : do_reset
  function automatic logic [17:0] rsp(logic dv, logic [7:0] src, logic [7:0] vec);
    return {1'b1, dv, src, vec};
  endfunction : rsp
  function automatic logic [7:0] icr_exp(int i, logic [7:0] x);
    return (x & 8'h9f) | ((i == SRC_TMR1 || i == SRC_TMR2) ? 8'h80 : 8'h00);
  endfunction : icr_exp
  initial begin
    #100000;
    err_count++;
    report_and_stop();
  end
  initial begin
    do_reset();
    chk("monitor limit", 32'h400, bm_limit);
    chk("monitor run", 32'h0, bm_run);
    rd(ADDR_MASK, MASK_RESET);
    rd(ADDR_PEND, 32'h0);
    rd(ADDR_CAUSE, CAUSE_HARD);
    rd(ADDR_PROT, PROT_RESET);
    rd(ADDR_WD_VEC, 32'h0);
    for (int i = 0; i < NUM_SRC; i++) rd(LVL_ADDR[i], LVL_RESET[i]);
    for (int i = 0; i < NUM_SRC; i++) begin
      d = 8'($random(seed));
      wr(LVL_ADDR[i], d);
      rd(LVL_ADDR[i], icr_exp(i, d));
      v = $random(seed);
      wr(ADDR_MASK, v);
      rd(ADDR_MASK, v & MASK_USED);
    end
    // distinct level and priority pairs, three sources sharing level 4
    for (int i = 0; i < NUM_SRC; i++) wr(LVL_ADDR[i], LVL_RESET[i]);
    wr(LVL_ADDR[SRC_TMR1], 8'h91);
    wr(LVL_ADDR[SRC_TMR2], 8'h93);
    wr(LVL_ADDR[7], 8'h12);
    wr(LVL_ADDR[SRC_WDOG], 8'h03);
    wr(ADDR_MASK, 32'h0);
    pulse(3'b011);
    cyc(3);
    chk("core level", 32'h4, core_level);
    rd(ADDR_PEND, 32'h600);
    wr(ADDR_MASK, 32'h600);
    cyc(3);
    chk("core level masked", 32'h0, core_level);
    rd(ADDR_PEND, 32'h600);
    wr(ADDR_MASK, 32'h0);
    cyc(3);
    ack(3'h4, rsp(1'b1, 8'h40, 8'd28));
    cyc(3);
    ack(3'h4, rsp(1'b1, 8'h20, 8'd28));
    cyc(3);
    rd(ADDR_PEND, 32'h0);
    slow <= 1'b1;
    pulse(3'b100);
    cyc(3);
    ack(3'h4, rsp(1'b0, 8'h80, 8'h00));
    ack(3'h5, rsp(1'b1, 8'h00, SPURIOUS_VEC));
    irq_pin_n <= 4'b1011;
    cyc(6);
    rd(ADDR_PEND, 32'h8);
    ack(3'h2, rsp(1'b0, 8'h04, 8'h00));
    irq_pin_n <= 4'hf;
    wr(ADDR_CAUSE, 32'h0);
    rd(ADDR_CAUSE, CAUSE_HARD);
    wr(ADDR_CAUSE, 32'h80);
    rd(ADDR_CAUSE, 32'h0);
    wr(ADDR_WD_VEC, 32'h77);
    rd(ADDR_WD_VEC, 32'h0);
    wr(ADDR_PROT, 32'h87);
    wr(ADDR_PROT, 32'h00);
    rd(ADDR_PROT, 32'h87);
    rd(LVL_ADDR[SRC_WDOG], 32'h1f);
    chk("monitor limit", 32'h80, bm_limit);
    chk("monitor run", 32'h1, bm_run);
    cyc(8);
    rd(ADDR_PEND, 32'h100);
    chk("core level", 32'h7, core_level);
    ack(3'h7, rsp(1'b1, 8'h10, 8'h77));
    cpu_halted <= 1'b1;
    cyc(3);
    chk("monitor frozen", 32'h0, bm_run);
    wr(ADDR_SYS_CFG, 32'h40);
    cyc(3);
    chk("monitor not frozen", 32'h1, bm_run);
    cpu_halted <= 1'b0;
    do_reset();
    v = wd_hits;
    wr(ADDR_PROT, 32'hc8);
    cyc(8);
    chk("watchdog resets", v + 1, wd_hits);
    rd(ADDR_CAUSE, CAUSE_WDOG);
    wr(ADDR_PROT, 32'hc8);
    for (int k = 0; k < 5; k++) begin
      wr(ADDR_WD_SVC, SVC_FIRST);
      wr(ADDR_WD_SVC, SVC_SECOND);
      cyc(10);
    end
    chk("watchdog serviced", v + 1, wd_hits);
    wr(ADDR_WD_SVC, SVC_FIRST);
    wr(ADDR_WD_SVC, 32'h11);
    wr(ADDR_WD_SVC, SVC_SECOND);
    cyc(20);
    chk("watchdog broken service", v + 2, wd_hits);
    for (int c = 0; c < 4; c++) begin
      do_reset();
      wr(ADDR_PROT, 32'h04 | c);
      cyc(3);
      chk("monitor code limit", 32'h400 >> c, bm_limit);
    end
    report_and_stop();
  end
endmodule : tb_top
